// ### shared/scw_regs.vh
// Constants for the screen crop window controller
`ifndef SCW_REGS_VH
`define SCW_REGS_VH

`define SCW_MAX_W        12'd1920
`define SCW_MAX_H        12'd1200
`define SCW_MIN_DIM      12'd16
`define SCW_OUT_W        12'd1920
`define SCW_OUT_H        12'd1080
`define SCW_DIM_ZERO     12'd0
`define SCW_DIM_ONE      12'd1

`define SCW_SHARP_MIN    4'd1
`define SCW_SHARP_MAX    4'd8
`define SCW_SHARP_DEF    4'd4

`define SCW_CMD_STEP_ORG 3'd0
`define SCW_CMD_STEP_EXT 3'd1
`define SCW_CMD_JUMP_ORG 3'd2
`define SCW_CMD_JUMP_EXT 3'd3
`define SCW_CMD_DEF_ORG  3'd4
`define SCW_CMD_DEF_EXT  3'd5
`define SCW_CMD_FULL     3'd6

`define SCW_DIR_LEFT     2'd0
`define SCW_DIR_RIGHT    2'd1
`define SCW_DIR_UP       2'd2
`define SCW_DIR_DOWN     2'd3

`define SCW_RAT_MANUAL   2'd0
`define SCW_RAT_16X9     2'd1
`define SCW_RAT_4X3      2'd2
`define SCW_R169_N       16'd16
`define SCW_R169_D       16'd9
`define SCW_R43_N        16'd4
`define SCW_R43_D        16'd3

`define SCW_REF_NONE     2'd0
`define SCW_REF_INT      2'd1
`define SCW_REF_EXT      2'd2

`define SCW_CLK_KHZ      50000
`define SCW_REP_START_MS 400
`define SCW_REP_MIN_MS   25
`define SCW_PRES_TMO_MS  100
`define SCW_REP_START_CYC (`SCW_REP_START_MS * `SCW_CLK_KHZ)
`define SCW_REP_MIN_CYC   (`SCW_REP_MIN_MS * `SCW_CLK_KHZ)
`define SCW_PRES_TMO_CYC  (`SCW_PRES_TMO_MS * `SCW_CLK_KHZ)

`define SCW_DIV_STEPS    5'd24
`define SCW_PIN_W        7
`endif

// ### design/scw_sync.v
// Three-stage pin synchroniser that only follows an agreed level
module scw_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  // Pins and clean levels
  input  wire [W-1:0] pin,
  output wire [W-1:0] lvl
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] lvl_q;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (rst) begin
          s1_q[i]  <= 1'b0;
          s2_q[i]  <= 1'b0;
          s3_q[i]  <= 1'b0;
          lvl_q[i] <= 1'b0;
        end else begin
          s1_q[i] <= pin[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            lvl_q[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate

  assign lvl = lvl_q;
endmodule // scw_sync

// ### design/scw_buf.v
// Two-entry buffer with registered ready, output stage plus skid slot
module scw_buf #(
  parameter W = 24
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  // Filling side
  input  wire         in_valid,
  input  wire [W-1:0] in_data,
  output wire         in_ready,
  // Draining side
  output wire         out_valid,
  output wire [W-1:0] out_data,
  input  wire         out_ready
);
  reg         out_valid_q;
  reg [W-1:0] out_data_q;
  reg         skid_valid_q;
  reg [W-1:0] skid_data_q;
  reg         in_ready_q;
  wire        drain = out_ready | ~out_valid_q;
  wire        take  = in_valid & in_ready_q;

  always @(posedge clk) begin
    if (rst) begin
      out_valid_q  <= 1'b0;
      out_data_q   <= {W{1'b0}};
      skid_valid_q <= 1'b0;
      skid_data_q  <= {W{1'b0}};
      in_ready_q   <= 1'b0;
    end else begin
      if (drain) begin
        if (skid_valid_q) begin
          out_valid_q <= 1'b1;
          out_data_q  <= skid_data_q;
        end else begin
          out_valid_q <= take;
          out_data_q  <= in_data;
        end
        skid_valid_q <= 1'b0;
        in_ready_q   <= 1'b1;
      end else if (take) begin
        // Receiver stalled: park the word rather than lose it
        skid_valid_q <= 1'b1;
        skid_data_q  <= in_data;
        in_ready_q   <= 1'b0;
      end else begin
        in_ready_q <= ~skid_valid_q;
      end
    end
  end

  assign in_ready  = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;
endmodule // scw_buf

// ### design/scw_top.v
// Screen crop window control: input sensing, selection geometry, output fill
`include "scw_regs.vh"
module scw_top #(
  parameter REP_START = `SCW_REP_START_CYC,
  parameter REP_MIN   = `SCW_REP_MIN_CYC,
  parameter PRES_TMO  = `SCW_PRES_TMO_CYC
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Input choice and analog size, host only
  input  wire        analog_sel,
  input  wire [11:0] cfg_res_w,
  input  wire [11:0] cfg_res_h,
  // Graphics input pins
  input  wire        dvi_de,
  input  wire        dvi_vs,
  input  wire        vga_vs,
  // Input status
  output reg         in_present_q,
  output reg  [11:0] in_width_q,
  output reg  [11:0] in_height_q,
  // Reference
  input  wire        ref_ext_sel,
  input  wire        ref_ext_det,
  input  wire        ref_pll_lock,
  input  wire        ref_hs,
  input  wire        ref_vs,
  input  wire [9:0]  tc_line,
  output reg  [1:0]  ref_kind_q,
  output reg         sync_lock_q,
  output reg         tc_gate_q,
  // Selection commands
  input  wire        cmd_valid,
  input  wire [2:0]  cmd_code,
  input  wire [1:0]  cmd_dir,
  input  wire        key_held,
  input  wire [1:0]  ratio_mode,
  output reg  [11:0] org_x_q,
  output reg  [11:0] org_y_q,
  output reg  [11:0] ext_w_q,
  output reg  [11:0] ext_h_q,
  // Output shaping
  input  wire [7:0]  border_px,
  input  wire [3:0]  sharp_set,
  output reg         lbox_q,
  output reg         pbox_q,
  output reg  [11:0] band_q,
  output reg  [3:0]  sharp_q,
  // Pixel stream in output raster coordinates
  input  wire        pix_valid,
  input  wire [23:0] pix_data,
  input  wire [11:0] pix_x,
  input  wire [11:0] pix_y,
  output wire        pix_ready,
  output wire        vid_valid,
  output wire [23:0] vid_data,
  input  wire        vid_ready
);
  wire [6:0] pins;
  scw_sync #(.W(`SCW_PIN_W)) u_sync (
    .clk (clk),
    .rst (rst),
    .pin ({ref_vs, ref_hs, ref_pll_lock, ref_ext_det, vga_vs, dvi_vs, dvi_de}),
    .lvl (pins)
  );
  wire de_s = pins[0];
  wire dvs_s = pins[1];
  wire avs_s = pins[2];
  wire rdet_s = pins[3];
  wire rlock_s = pins[4];
  wire rhs_s = pins[5];
  wire rvs_s = pins[6];

  // Input measurement and presence
  reg         de_q, dvs_q, avs_q, rhs_q, rvs_q;
  reg  [11:0] pix_cnt_q, line_cnt_q, meas_w_q, meas_h_q;
  reg  [24:0] tmo_q;
  reg  [9:0]  ref_line_q;
  reg  [11:0] fw_q, fh_q;
  wire        sel_vs_rise = analog_sel ? (avs_s & ~avs_q) : (dvs_s & ~dvs_q);

  always @(posedge clk) begin
    if (rst) begin
      {de_q, dvs_q, avs_q, rhs_q, rvs_q} <= 5'h00;
      pix_cnt_q <= `SCW_DIM_ZERO;
      line_cnt_q <= `SCW_DIM_ZERO;
      meas_w_q <= `SCW_DIM_ZERO;
      meas_h_q <= `SCW_DIM_ZERO;
      tmo_q <= 25'h0000000;
      in_present_q <= 1'b0;
      in_width_q <= `SCW_DIM_ZERO;
      in_height_q <= `SCW_DIM_ZERO;
      fw_q <= `SCW_MAX_W;
      fh_q <= `SCW_MAX_H;
      ref_line_q <= 10'h000;
      ref_kind_q <= `SCW_REF_INT;
      sync_lock_q <= 1'b0;
      tc_gate_q <= 1'b0;
      sharp_q <= `SCW_SHARP_DEF;
    end else begin
      {de_q, dvs_q, avs_q, rhs_q, rvs_q} <= {de_s, dvs_s, avs_s, rhs_s, rvs_s};
      // Saturating counts keep an oversize raster from wrapping
      if (de_s && pix_cnt_q != `SCW_MAX_W) begin
        pix_cnt_q <= pix_cnt_q + `SCW_DIM_ONE;
      end else if (!de_s) begin
        pix_cnt_q <= `SCW_DIM_ZERO;
      end
      if (!de_s && de_q) begin
        meas_w_q <= pix_cnt_q;
        if (line_cnt_q != `SCW_MAX_H) begin
          line_cnt_q <= line_cnt_q + `SCW_DIM_ONE;
        end
      end
      if (dvs_s && !dvs_q) begin
        meas_h_q <= line_cnt_q;
        line_cnt_q <= `SCW_DIM_ZERO;
      end
      if (sel_vs_rise) begin
        tmo_q <= PRES_TMO[24:0];
      end else if (tmo_q != 25'h0000000) begin
        tmo_q <= tmo_q - 25'h0000001;
      end
      in_present_q <= (tmo_q != 25'h0000000);
      // Analog cannot be sensed, so the configured size stands in
      if (analog_sel) begin
        fw_q <= (cfg_res_w > `SCW_MAX_W) ? `SCW_MAX_W : cfg_res_w;
        fh_q <= (cfg_res_h > `SCW_MAX_H) ? `SCW_MAX_H : cfg_res_h;
      end else begin
        fw_q <= meas_w_q;
        fh_q <= meas_h_q;
      end
      in_width_q <= fw_q;
      in_height_q <= fh_q;
      // Reference kind, lock and timecode line gate
      if (!ref_ext_sel) begin
        ref_kind_q <= `SCW_REF_INT;
      end else begin
        ref_kind_q <= rdet_s ? `SCW_REF_EXT : `SCW_REF_NONE;
      end
      sync_lock_q <= rlock_s & (~ref_ext_sel | rdet_s);
      if (rvs_s && !rvs_q) begin
        ref_line_q <= 10'h000;
      end else if (rhs_s && !rhs_q) begin
        ref_line_q <= ref_line_q + 10'h001;
      end
      tc_gate_q <= (ref_line_q == tc_line);
      if (sharp_set < `SCW_SHARP_MIN) begin
        sharp_q <= `SCW_SHARP_MIN;
      end else if (sharp_set > `SCW_SHARP_MAX) begin
        sharp_q <= `SCW_SHARP_MAX;
      end else begin
        sharp_q <= sharp_set;
      end
    end
  end

  // Hold-to-repeat for step commands
  reg         rep_on_q;
  reg  [24:0] rep_cnt_q, rep_int_q;
  reg  [2:0]  rep_code_q;
  reg  [1:0]  rep_dir_q;
  wire        is_step = (cmd_code == `SCW_CMD_STEP_ORG) || (cmd_code == `SCW_CMD_STEP_EXT);
  wire        rep_fire = rep_on_q & key_held & (rep_cnt_q == 25'h0000000);
  wire [24:0] rep_half = rep_int_q >> 1;
  wire [24:0] rep_next = (rep_half < REP_MIN[24:0]) ? REP_MIN[24:0] : rep_half;

  always @(posedge clk) begin
    if (rst) begin
      rep_on_q <= 1'b0;
      rep_cnt_q <= 25'h0000000;
      rep_int_q <= 25'h0000000;
      rep_code_q <= `SCW_CMD_STEP_ORG;
      rep_dir_q <= `SCW_DIR_LEFT;
    end else if (cmd_valid) begin
      rep_on_q <= is_step & key_held;
      rep_cnt_q <= REP_START[24:0];
      rep_int_q <= REP_START[24:0];
      rep_code_q <= cmd_code;
      rep_dir_q <= cmd_dir;
    end else if (!key_held) begin
      rep_on_q <= 1'b0;
    end else if (rep_fire) begin
      rep_int_q <= rep_next;
      rep_cnt_q <= rep_next;
    end else if (rep_on_q) begin
      rep_cnt_q <= rep_cnt_q - 25'h0000001;
    end
  end

  // Selection geometry
  wire        go = cmd_valid | rep_fire;
  wire [2:0]  code = cmd_valid ? cmd_code : rep_code_q;
  wire [1:0]  dir = cmd_valid ? cmd_dir : rep_dir_q;
  wire        fixed = (ratio_mode != `SCW_RAT_MANUAL);
  wire [15:0] rn = (ratio_mode == `SCW_RAT_4X3) ? `SCW_R43_N : `SCW_R169_N;
  wire [15:0] rd = (ratio_mode == `SCW_RAT_4X3) ? `SCW_R43_D : `SCW_R169_D;
  reg  [11:0] nx, ny, nw, nh, aw, ah, base, cap, fitw, fith;
  reg  [15:0] t;
  reg         drive_h;

  function [11:0] sat12;
    input [15:0] v;
    sat12 = (v > {4'h0, `SCW_MAX_W}) ? `SCW_MAX_W : v[11:0];
  endfunction

  always @* begin
    nx = org_x_q;
    ny = org_y_q;
    nw = ext_w_q;
    nh = ext_h_q;
    drive_h = 1'b0;
    if (go) begin
      case (code)
        `SCW_CMD_STEP_ORG: begin
          case (dir)
            `SCW_DIR_LEFT: nx = (org_x_q == `SCW_DIM_ZERO) ? org_x_q : org_x_q - `SCW_DIM_ONE;
            `SCW_DIR_RIGHT: nx = org_x_q + `SCW_DIM_ONE;
            `SCW_DIR_UP: ny = (org_y_q == `SCW_DIM_ZERO) ? org_y_q : org_y_q - `SCW_DIM_ONE;
            default: ny = org_y_q + `SCW_DIM_ONE;
          endcase
        end
        `SCW_CMD_STEP_EXT: begin
          case (dir)
            `SCW_DIR_LEFT: nw = ext_w_q - `SCW_DIM_ONE;
            `SCW_DIR_RIGHT: nw = ext_w_q + `SCW_DIM_ONE;
            `SCW_DIR_UP: nh = ext_h_q - `SCW_DIM_ONE;
            default: nh = ext_h_q + `SCW_DIM_ONE;
          endcase
          drive_h = dir[1];
        end
        `SCW_CMD_JUMP_ORG: begin
          case (dir)
            `SCW_DIR_LEFT: nx = `SCW_DIM_ZERO;
            `SCW_DIR_RIGHT: nx = `SCW_MAX_W;
            `SCW_DIR_UP: ny = `SCW_DIM_ZERO;
            default: ny = `SCW_MAX_H;
          endcase
        end
        `SCW_CMD_JUMP_EXT: begin
          case (dir)
            `SCW_DIR_RIGHT: nw = `SCW_MAX_W;
            `SCW_DIR_DOWN: begin
              nh = `SCW_MAX_H;
              drive_h = 1'b1;
            end
            default: begin
              nw = `SCW_MIN_DIM;
              nh = `SCW_MIN_DIM;
            end
          endcase
        end
        `SCW_CMD_DEF_ORG: begin
          nx = `SCW_DIM_ZERO;
          ny = `SCW_DIM_ZERO;
        end
        `SCW_CMD_DEF_EXT: begin
          nw = `SCW_MAX_W;
          nh = `SCW_MAX_H;
        end
        `SCW_CMD_FULL: begin
          nx = `SCW_DIM_ZERO;
          ny = `SCW_DIM_ZERO;
          nw = `SCW_MAX_W;
          nh = `SCW_MAX_H;
        end
        default: ;
      endcase
    end
    // Origin is held so the current size still fits; far jumps land on the edge
    if (nx > fw_q - ext_w_q || fw_q < ext_w_q) begin
      nx = (fw_q > ext_w_q) ? fw_q - ext_w_q : `SCW_DIM_ZERO;
    end
    if (ny > fh_q - ext_h_q || fh_q < ext_h_q) begin
      ny = (fh_q > ext_h_q) ? fh_q - ext_h_q : `SCW_DIM_ZERO;
    end
    aw = fw_q - nx;
    ah = fh_q - ny;
    if (fixed) begin
      t = {4'h0, nh} * rn / rd;
      base = drive_h ? sat12(t) : nw;
      t = {4'h0, ah} * rn / rd;
      cap = (sat12(t) < aw) ? sat12(t) : aw;
      fitw = (base < `SCW_MIN_DIM) ? `SCW_MIN_DIM : base;
      fitw = (fitw > cap) ? cap : fitw;
      t = {4'h0, fitw} * rd / rn;
      fith = t[11:0];
    end else begin
      cap = aw;
      base = nw;
      t = 16'h0000;
      fitw = (nw < `SCW_MIN_DIM) ? `SCW_MIN_DIM : nw;
      fitw = (fitw > aw) ? aw : fitw;
      fith = (nh < `SCW_MIN_DIM) ? `SCW_MIN_DIM : nh;
      fith = (fith > ah) ? ah : fith;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      org_x_q <= `SCW_DIM_ZERO;
      org_y_q <= `SCW_DIM_ZERO;
      ext_w_q <= `SCW_MIN_DIM;
      ext_h_q <= `SCW_MIN_DIM;
    end else begin
      // Refit every cycle so a frame or ratio change reclamps at once
      org_x_q <= nx;
      org_y_q <= ny;
      ext_w_q <= fitw;
      ext_h_q <= fith;
    end
  end

  // Serial divider for band size, reruns continuously
  reg  [23:0] dv_num_q;
  reg  [11:0] dv_den_q, dv_quo_q;
  reg  [12:0] dv_rem_q;
  reg  [4:0]  dv_cnt_q;
  reg         dv_wide_q;
  wire [23:0] wide_a = ext_w_q * `SCW_OUT_H;
  wire [23:0] wide_b = ext_h_q * `SCW_OUT_W;
  wire [12:0] rem_sh = {dv_rem_q[11:0], dv_num_q[23]};
  wire [11:0] odim = dv_wide_q ? `SCW_OUT_H : `SCW_OUT_W;
  // Last quotient bit lands on the final step, so the band must see it early
  wire [11:0] quo_nx = {dv_quo_q[10:0], rem_sh >= {1'b0, dv_den_q}};

  always @(posedge clk) begin
    if (rst) begin
      dv_num_q <= 24'h000000;
      dv_den_q <= `SCW_DIM_ZERO;
      dv_quo_q <= `SCW_DIM_ZERO;
      dv_rem_q <= 13'h0000;
      dv_cnt_q <= 5'h00;
      dv_wide_q <= 1'b0;
      lbox_q <= 1'b0;
      pbox_q <= 1'b0;
      band_q <= `SCW_DIM_ZERO;
    end else if (dv_cnt_q == 5'h00) begin
      dv_wide_q <= (wide_a > wide_b);
      dv_num_q <= (wide_a > wide_b) ? wide_b : wide_a;
      dv_den_q <= (wide_a > wide_b) ? ext_w_q : ext_h_q;
      dv_rem_q <= 13'h0000;
      dv_quo_q <= `SCW_DIM_ZERO;
      dv_cnt_q <= `SCW_DIV_STEPS;
    end else begin
      dv_num_q <= {dv_num_q[22:0], 1'b0};
      if (rem_sh >= {1'b0, dv_den_q}) begin
        dv_rem_q <= rem_sh - {1'b0, dv_den_q};
        dv_quo_q <= {dv_quo_q[10:0], 1'b1};
      end else begin
        dv_rem_q <= rem_sh;
        dv_quo_q <= {dv_quo_q[10:0], 1'b0};
      end
      if (dv_cnt_q == 5'h01) begin
        lbox_q <= dv_wide_q;
        pbox_q <= ~dv_wide_q & (wide_a != wide_b);
        band_q <= (quo_nx < odim) ? (odim - quo_nx) >> 1 : `SCW_DIM_ZERO;
      end
      dv_cnt_q <= dv_cnt_q - 5'h01;
    end
  end

  // Blanking of bands and border on the way out
  wire [11:0] bdr = {4'h0, border_px};
  wire [11:0] cx0 = (pbox_q ? band_q : `SCW_DIM_ZERO) + bdr;
  wire [11:0] cx1 = (pbox_q ? `SCW_OUT_W - band_q : `SCW_OUT_W) - bdr;
  wire [11:0] cy0 = (lbox_q ? band_q : `SCW_DIM_ZERO) + bdr;
  wire [11:0] cy1 = (lbox_q ? `SCW_OUT_H - band_q : `SCW_OUT_H) - bdr;
  wire        black = (pix_x < cx0) || (pix_x >= cx1) || (pix_y < cy0) || (pix_y >= cy1);
  wire [23:0] shaped = black ? 24'h000000 : pix_data;

  scw_buf #(.W(24)) u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (pix_valid),
    .in_data   (shaped),
    .in_ready  (pix_ready),
    .out_valid (vid_valid),
    .out_data  (vid_data),
    .out_ready (vid_ready)
  );
endmodule // scw_top

// ### bench/scw_gfx_model.sv
// Graphics source model: small active frame with vsync on both inputs
module scw_gfx_model #(
  parameter int AW = 64,
  parameter int AH = 8
) (
  // Clock and enable
  input  wire logic clk,
  input  wire logic en,
  // Graphics pins
  output logic      dvi_de,
  output logic      dvi_vs,
  output logic      vga_vs
);
  timeunit 1ns;
  timeprecision 1ns;
  int px = 0;
  int ln = 0;
  // Lines idle low when the source is unplugged
  always @(posedge clk) begin
    px <= (px == AW + 15) ? 0 : px + 1;
    if (px == AW + 15) begin
      ln <= (ln == AH + 1) ? 0 : ln + 1;
    end
    dvi_de <= en && ln < AH && px < AW;
    dvi_vs <= en && ln == AH + 1;
    vga_vs <= en && ln == AH + 1;
  end
endmodule // scw_gfx_model

// ### bench/scw_top_monitor.sv
// Checker for selection geometry, status and output stream
module scw_top_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Commands
  input wire logic        cmd_valid,
  input wire logic [2:0]  cmd_code,
  input wire logic [1:0]  cmd_dir,
  input wire logic        key_held,
  input wire logic [1:0]  ratio_mode,
  // Geometry
  input wire logic [11:0] in_width_q,
  input wire logic [11:0] org_x_q,
  input wire logic [11:0] org_y_q,
  input wire logic [11:0] ext_w_q,
  input wire logic [11:0] ext_h_q,
  // Status and output
  input wire logic [3:0]  sharp_set,
  input wire logic [3:0]  sharp_q,
  input wire logic        ref_ext_sel,
  input wire logic [1:0]  ref_kind_q,
  input wire logic        lbox_q,
  input wire logic        pbox_q,
  input wire logic        vid_valid,
  input wire logic [23:0] vid_data,
  input wire logic        vid_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_step_right;
    cmd_valid && cmd_code == 3'h0 && cmd_dir == 2'h1 && !key_held
      && org_x_q + ext_w_q < in_width_q |=> org_x_q == $past(org_x_q) + 12'h001;
  endproperty
  a_step_right: assert property (p_step_right) else $error("step right not one pixel");
  property p_org_size;
    cmd_valid && cmd_code == 3'h0 && !key_held && ratio_mode == 2'h0
      |=> $stable(ext_w_q) && $stable(ext_h_q);
  endproperty
  a_org_size: assert property (p_org_size) else $error("origin step changed size");
  property p_ext_org;
    cmd_valid && cmd_code == 3'h1 |=> $stable(org_x_q) && $stable(org_y_q);
  endproperty
  a_ext_org: assert property (p_ext_org) else $error("size step moved origin");
  property p_jump_min;
    cmd_valid && cmd_code == 3'h3 && (cmd_dir == 2'h0 || cmd_dir == 2'h2)
      && ratio_mode == 2'h0 |=> ext_w_q == 12'h010 && ext_h_q == 12'h010;
  endproperty
  a_jump_min: assert property (p_jump_min) else $error("size jump not minimum");
  property p_org_home;
    cmd_valid && (cmd_code == 3'h4 || cmd_code == 3'h6) |=> org_x_q == 12'h000 && org_y_q == 12'h000;
  endproperty
  a_org_home: assert property (p_org_home) else $error("origin not home");
  property p_ratio;
    ratio_mode == 2'h1 && $past(ratio_mode) == 2'h1 && !$past(cmd_valid)
      && ext_w_q >= 12'h020 |-> ext_h_q == 12'((ext_w_q * 9) >> 4);
  endproperty
  a_ratio: assert property (p_ratio) else $error("wide ratio not kept");
  property p_sharp;
    sharp_set >= 4'h1 && sharp_set <= 4'h8 |=> sharp_q == $past(sharp_set);
  endproperty
  a_sharp: assert property (p_sharp) else $error("sharpness not taken");
  property p_ref_int;
    !ref_ext_sel && !$past(ref_ext_sel) |-> ref_kind_q == 2'h1;
  endproperty
  a_ref_int: assert property (p_ref_int) else $error("internal reference not shown");
  property p_box;
    !(lbox_q && pbox_q);
  endproperty
  a_box: assert property (p_box) else $error("both fill kinds at once");
  property p_vid_hold;
    vid_valid && !vid_ready |=> vid_valid && $stable(vid_data);
  endproperty
  a_vid_hold: assert property (p_vid_hold) else $error("stalled word dropped");
endmodule // scw_top_monitor

bind scw_top scw_top_monitor u_mon (.clk, .rst, .cmd_valid, .cmd_code, .cmd_dir, .key_held,
  .ratio_mode, .in_width_q, .org_x_q, .org_y_q, .ext_w_q, .ext_h_q, .sharp_set, .sharp_q,
  .ref_ext_sel, .ref_kind_q, .lbox_q, .pbox_q, .vid_valid, .vid_data, .vid_ready);

// ### bench/scw_top_tb.sv
// Self-checking bench for the screen crop window controller
`include "scw_regs.vh"
module scw_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PTMO = 2000;
  logic        clk = 1'b0, rst = 1'b1, analog_sel = 1'b0, cmd_valid = 1'b0, key_held = 1'b0;
  logic        gen_en = 1'b0, ref_ext_sel = 1'b0, ref_ext_det = 1'b0, ref_lock = 1'b0;
  logic [9:0]  tc_line = 10'h003;
  logic        pix_valid = 1'b0, vid_ready = 1'b1;
  logic [11:0] cfg_res_w = 12'h000, cfg_res_h = 12'h000, pix_x = 12'h000, pix_y = 12'h000;
  logic [2:0]  cmd_code = 3'h7;
  logic [1:0]  cmd_dir = 2'h0, ratio_mode = 2'h0;
  logic [7:0]  border_px = 8'h00;
  logic [3:0]  sharp_set = 4'h4;
  logic [23:0] pix_data = 24'h000000;
  wire         dvi_de, dvi_vs, vga_vs, in_present_q, lbox_q, pbox_q, pix_ready, vid_valid;
  wire         sync_lock_q, tc_gate_q;
  wire  [11:0] in_width_q, in_height_q, org_x_q, org_y_q, ext_w_q, ext_h_q, band_q;
  wire  [1:0]  ref_kind_q;
  wire  [3:0]  sharp_q;
  wire  [23:0] vid_data;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          ox, oy, w, h, fw, fh, acc;

  scw_top #(.REP_START(40), .REP_MIN(5), .PRES_TMO(PTMO)) u_dut (
    .clk, .rst, .analog_sel, .cfg_res_w, .cfg_res_h, .dvi_de, .dvi_vs, .vga_vs,
    .in_present_q, .in_width_q, .in_height_q, .ref_ext_sel, .ref_ext_det,
    .ref_pll_lock(ref_lock), .ref_hs(dvi_de), .ref_vs(dvi_vs), .tc_line,
    .ref_kind_q, .sync_lock_q, .tc_gate_q, .cmd_valid, .cmd_code, .cmd_dir,
    .key_held, .ratio_mode, .org_x_q, .org_y_q, .ext_w_q, .ext_h_q, .border_px,
    .sharp_set, .lbox_q, .pbox_q, .band_q, .sharp_q, .pix_valid, .pix_data,
    .pix_x, .pix_y, .pix_ready, .vid_valid, .vid_data, .vid_ready);
  scw_gfx_model u_gfx (.clk, .en(gen_en), .dvi_de, .dvi_vs, .vga_vs);

  initial begin
    forever #10 clk = ~clk;
  end

  function automatic int lim(int v, int lo, int hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction

  task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic chk4;
    chk("org_x", org_x_q, 24'(ox));
    chk("org_y", org_y_q, 24'(oy));
    chk("ext_w", ext_w_q, 24'(w));
    chk("ext_h", ext_h_q, 24'(h));
  endtask

  task automatic send(input logic [2:0] c, input logic [1:0] d);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_dir <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(posedge clk);
  endtask

  // Manual-ratio model of the selection, frame fw by fh
  task automatic run(input logic [2:0] c, input logic [1:0] d);
    int dx;
    int dy;
    dx = int'(d == `SCW_DIR_RIGHT) - int'(d == `SCW_DIR_LEFT);
    dy = int'(d == `SCW_DIR_DOWN) - int'(d == `SCW_DIR_UP);
    send(c, d);
    case (c)
      `SCW_CMD_STEP_ORG: begin
        ox = lim(ox + dx, 0, fw - w);
        oy = lim(oy + dy, 0, fh - h);
      end
      `SCW_CMD_STEP_EXT: begin
        w = lim(w + dx, 16, fw - ox);
        h = lim(h + dy, 16, fh - oy);
      end
      `SCW_CMD_JUMP_ORG: begin
        ox = lim(ox + dx * 4096, 0, fw - w);
        oy = lim(oy + dy * 4096, 0, fh - h);
      end
      `SCW_CMD_JUMP_EXT: begin
        w = (dx < 0 || dy < 0) ? 16 : lim(w + dx * 4096, 16, fw - ox);
        h = (dx < 0 || dy < 0) ? 16 : lim(h + dy * 4096, 16, fh - oy);
      end
      `SCW_CMD_DEF_ORG: begin
        ox = 0;
        oy = 0;
      end
      `SCW_CMD_DEF_EXT: begin
        w = fw - ox;
        h = fh - oy;
      end
      default: begin
        ox = 0;
        oy = 0;
        w = fw;
        h = fh;
      end
    endcase
    chk4;
  endtask

  task automatic box(input logic l, input logic p);
    repeat (60) @(posedge clk);
    chk("lbox", lbox_q, 24'(l));
    chk("pbox", pbox_q, 24'(p));
  endtask

  task automatic give_verdict;
    $display("Counts: %0d compared, %0d mismatches", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict;
  end

  initial begin
    void'($urandom(6));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    {ox, oy, w, h} = {32'd0, 32'd0, 32'd16, 32'd16};
    chk4;
    chk("sharp", sharp_q, 24'h4);
    chk("ref_kind", ref_kind_q, 24'h1);
    chk("present", in_present_q, 24'h0);
    $display("TEST reset done");
    analog_sel <= 1'b1;
    cfg_res_w <= 12'h7ff;
    cfg_res_h <= 12'h5dc;
    repeat (5) @(posedge clk);
    chk("in_w", in_width_q, 24'h780);
    chk("in_h", in_height_q, 24'h4b0);
    cfg_res_w <= 12'h500;
    cfg_res_h <= 12'h400;
    fw = 1280;
    fh = 1024;
    repeat (5) @(posedge clk);
    chk("in_w", in_width_q, 24'h500);
    chk("in_h", in_height_q, 24'h400);
    run(`SCW_CMD_FULL, `SCW_DIR_LEFT);
    box(1'b0, 1'b1);
    chk("band", band_q, 24'h11d);
    run(`SCW_CMD_JUMP_EXT, `SCW_DIR_UP);
    run(`SCW_CMD_JUMP_EXT, `SCW_DIR_RIGHT);
    box(1'b1, 1'b0);
    repeat (400) run(3'($urandom_range(6, 0)), 2'($urandom));
    $display("TEST geometry done");
    run(`SCW_CMD_JUMP_EXT, `SCW_DIR_LEFT);
    run(`SCW_CMD_DEF_ORG, `SCW_DIR_LEFT);
    key_held <= 1'b1;
    run(`SCW_CMD_STEP_ORG, `SCW_DIR_RIGHT);
    repeat (30) @(posedge clk);
    chk("hold", org_x_q, 24'(ox));
    repeat (300) @(posedge clk);
    chk("repeat", 24'(org_x_q > ox + 3), 24'h1);
    key_held <= 1'b0;
    run(`SCW_CMD_DEF_ORG, `SCW_DIR_LEFT);
    $display("TEST held key done");
    ratio_mode <= `SCW_RAT_16X9;
    send(`SCW_CMD_FULL, `SCW_DIR_LEFT);
    chk("w169", ext_w_q, 24'h500);
    chk("h169", ext_h_q, 24'h2d0);
    box(1'b0, 1'b0);
    send(`SCW_CMD_STEP_EXT, `SCW_DIR_LEFT);
    chk("h_step", ext_h_q, 24'h2cf);
    ratio_mode <= `SCW_RAT_4X3;
    send(`SCW_CMD_DEF_EXT, `SCW_DIR_LEFT);
    chk("w43", ext_w_q, 24'h500);
    chk("h43", ext_h_q, 24'h3c0);
    ratio_mode <= `SCW_RAT_MANUAL;
    run(`SCW_CMD_FULL, `SCW_DIR_LEFT);
    $display("TEST ratio done");
    // Edge pixel lies in the side band, so it must come out black
    border_px <= 8'h02;
    pix_y <= 12'h21c;
    pix_data <= 24'($urandom);
    vid_ready <= 1'b0;
    pix_valid <= 1'b1;
    acc = 0;
    repeat (6) begin
      @(posedge clk);
      acc += int'(pix_ready === 1'b1);
    end
    pix_valid <= 1'b0;
    chk("accepted", 24'(acc), 24'h2);
    vid_ready <= 1'b1;
    acc = 0;
    repeat (5) begin
      @(posedge clk);
      if (vid_valid === 1'b1) begin
        acc++;
        chk("black", vid_data, 24'h0);
      end
    end
    chk("drained", 24'(acc), 24'h2);
    $display("TEST stream done");
    for (int i = 0; i < 16; i++) begin
      sharp_set <= 4'(i);
      repeat (2) @(posedge clk);
      chk("sharp", sharp_q, 24'(lim(i, 1, 8)));
    end
    ref_ext_sel <= 1'b1;
    ref_lock <= 1'b1;
    repeat (10) @(posedge clk);
    chk("ref_none", ref_kind_q, 24'h0);
    chk("lock_none", sync_lock_q, 24'h0);
    ref_ext_det <= 1'b1;
    repeat (10) @(posedge clk);
    chk("ref_ext", ref_kind_q, 24'h2);
    chk("lock", sync_lock_q, 24'h1);
    ref_ext_sel <= 1'b0;
    repeat (3) @(posedge clk);
    chk("ref_int", ref_kind_q, 24'h1);
    $display("TEST status done");
    analog_sel <= 1'b0;
    gen_en <= 1'b1;
    repeat (5000) @(posedge clk);
    chk("present", in_present_q, 24'h1);
    chk("meas_w", in_width_q, 24'h40);
    chk("meas_h", in_height_q, 24'h8);
    // Source doubles as reference: one line in ten is the timecode line
    acc = 0;
    repeat (800) begin
      @(posedge clk);
      acc += int'(tc_gate_q === 1'b1);
    end
    chk("tc_gate", 24'(acc), 24'h50);
    gen_en <= 1'b0;
    repeat (PTMO + 900) @(posedge clk);
    chk("absent", in_present_q, 24'h0);
    $display("TEST digital done");
    give_verdict;
  end
endmodule // scw_top_tb
